// >>> core/mpm_defs.svh
// Address map and timing constants for the program and data memory mapper
`ifndef MPM_DEFS_SVH
`define MPM_DEFS_SVH
`define MPM_RESET_PC      16'h0000
`define MPM_VEC_BASE      16'h0003
`define MPM_VEC_SHIFT     3
`define MPM_PAGE_BYTES    256
`define MPM_PAGE_AW       8
`define MPM_ERASED_BYTE   8'hFF
`define MPM_ALE_DIV_6T    3'h3
`define MPM_ALE_DIV_12T   3'h6
`define MPM_APP_PAGES     256
`define MPM_DATA_PAGES    8
`define MPM_LDR_PAGES     16
`define MPM_CFG_PAGES     1
`define MPM_AUXILIARY_RAM_BYTES    1024
`define MPM_IRAM_BYTES    256
`endif

// >>> core/mpm_pkg.sv
// Types shared by the program and data memory mapper
package mpm_pkg;
  typedef enum logic [1:0] {MPM_BANK_APP = 2'h0, MPM_BANK_DATA = 2'h1,
                            MPM_BANK_LDR = 2'h2, MPM_BANK_CFG = 2'h3} mpm_bank_t;
  typedef enum logic [1:0] {MPM_OP_READ = 2'h0, MPM_OP_PROG = 2'h1,
                            MPM_OP_ERASE = 2'h2, MPM_OP_NONE = 2'h3} mpm_op_t;
  typedef enum logic {MPM_FL_IDLE = 1'b0, MPM_FL_ERASE = 1'b1} mpm_fl_state_t;
  typedef struct packed {
    logic       we;
    logic       wide;
    logic [7:0] page;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mpm_xdata_req_t;
  typedef struct packed {
    mpm_op_t    op;
    mpm_bank_t  bank;
    logic       tool;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mpm_flash_req_t;
endpackage

// >>> core/mpm_memory_map.sv
// Program fetch mapping, vectors, data spaces, flash banks and address latch strobe
`timescale 1ns/1ps
`include "mpm_defs.svh"
// Function
// - Reset fetch starts at address zero
// - Vectors at 0003H plus eight per source
// - Unused vector slots are plain program memory
// - Data space separate from program space
// - 256 byte internal RAM, 64k external data
// - External data: 16/8-bit address, read/write strobes
// - 1k auxiliary RAM via external data move
// - Flash has app, data, loader, config banks
// - Every bank is whole 256-byte pages
// - Page erase, byte program, byte read
// - Application bank up to 64k serves fetches
// - Code read returns application flash data
// - Each boot bank may reprogram the other
// - Loader boot maps PC zero to loader start
// - Loader vectors resolve inside loader bank
// - Six-clock mode: strobe at clock over three
// - Access select captured once after reset
// - PC past internal bank goes external
// - Access select low: all fetches external
module mpm_memory_map
  import mpm_pkg::*;
#(
  parameter int APP_PAGES  = `MPM_APP_PAGES,
  parameter int DATA_PAGES = `MPM_DATA_PAGES,
  parameter int LDR_PAGES  = `MPM_LDR_PAGES,
  parameter int CFG_PAGES  = `MPM_CFG_PAGES,
  parameter int AUXILIARY_RAM_BYTES = `MPM_AUXILIARY_RAM_BYTES,
  parameter int IRAM_BYTES = `MPM_IRAM_BYTES
)(
  input  wire logic           i_clk,
  input  wire logic           i_rst_n,
  input  wire logic           i_external_access_select,
  input  wire logic           i_boot_loader,
  input  wire logic           i_six_clock_cycle_mode,
  input  wire logic           i_fetch_valid,
  input  wire logic [15:0]    i_fetch_pc,
  input  wire logic           i_vec_valid,
  input  wire logic [4:0]     i_vec_num,
  input  wire logic           i_iram_valid,
  input  wire logic           i_iram_we,
  input  wire logic [7:0]     i_iram_addr,
  input  wire logic [7:0]     i_iram_wdata,
  input  wire logic           i_xdata_valid,
  input  wire mpm_xdata_req_t i_xdata,
  input  wire logic           i_flash_valid,
  input  wire mpm_flash_req_t i_flash,
  output logic                o_fetch_valid,
  output logic                o_fetch_ext,
  output logic [7:0]          o_fetch_data,
  output logic                o_psen_n,
  output logic [15:0]         o_ext_addr,
  output logic [7:0]          o_ext_wdata,
  output logic                o_ext_rd_n,
  output logic                o_ext_wr_n,
  output logic                o_vec_valid,
  output logic [15:0]         o_vec_pc,
  output logic                o_iram_valid,
  output logic [7:0]          o_iram_rdata,
  output logic                o_xdata_valid,
  output logic                o_xdata_ext,
  output logic [7:0]          o_xdata_rdata,
  output logic                o_flash_busy,
  output logic                o_flash_done,
  output logic                o_flash_err,
  output logic [7:0]          o_flash_rdata,
  output logic                o_ale,
  output logic                o_boot_loader,
  output logic                o_ext_access_locked,
  output logic                o_strap_done
);
  localparam int PB         = `MPM_PAGE_BYTES;
  localparam int APP_BYTES  = APP_PAGES * PB;
  localparam int DATA_BYTES = DATA_PAGES * PB;
  localparam int LDR_BYTES  = LDR_PAGES * PB;
  localparam int CFG_BYTES  = CFG_PAGES * PB;
  localparam int DATA_BASE  = APP_BYTES;
  localparam int LDR_BASE   = DATA_BASE + DATA_BYTES;
  localparam int CFG_BASE   = LDR_BASE + LDR_BYTES;
  localparam int TOTAL      = CFG_BASE + CFG_BYTES;
  localparam int FAW        = $clog2(TOTAL);
  localparam int XAW        = $clog2(AUXILIARY_RAM_BYTES);
  localparam int IAW        = $clog2(IRAM_BYTES);

  // Four banks laid out back to back in one array
  logic [7:0] flash_mem [TOTAL];
  logic [7:0] auxiliary_ram_mem  [AUXILIARY_RAM_BYTES];
  logic [7:0] iram_mem  [IRAM_BYTES];

  function automatic int bank_base(input mpm_bank_t b);
    unique case (b)
      MPM_BANK_APP:  return 0;
      MPM_BANK_DATA: return DATA_BASE;
      MPM_BANK_LDR:  return LDR_BASE;
      MPM_BANK_CFG:  return CFG_BASE;
    endcase
  endfunction

  function automatic int bank_bytes(input mpm_bank_t b);
    unique case (b)
      MPM_BANK_APP:  return APP_BYTES;
      MPM_BANK_DATA: return DATA_BYTES;
      MPM_BANK_LDR:  return LDR_BYTES;
      MPM_BANK_CFG:  return CFG_BYTES;
    endcase
  endfunction

  function automatic logic [15:0] vec_addr(input logic [4:0] n);
    return `MPM_VEC_BASE + (16'(n) << `MPM_VEC_SHIFT);
  endfunction

  // Straps are sampled on the first edge after release, never under reset
  logic strap_done_reg;
  logic ea_lock_reg;
  logic boot_ldr_reg;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      strap_done_reg <= 1'b0;
      ea_lock_reg    <= 1'b0;
      boot_ldr_reg   <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      ea_lock_reg    <= i_external_access_select;
      boot_ldr_reg   <= i_boot_loader;
    end
  end
  assign o_strap_done        = strap_done_reg;
  assign o_ext_access_locked = ea_lock_reg;
  assign o_boot_loader       = boot_ldr_reg;

  // Program fetch mapping; flash read requests go through the flash controller, not this path
  logic           fetch_int;
  logic [FAW-1:0] fetch_idx;
  always_comb
  begin
    fetch_int = 1'b0;
    fetch_idx = '0;
    if (ea_lock_reg)
    begin
      if (boot_ldr_reg)
      begin
        fetch_int = (int'(i_fetch_pc) < LDR_BYTES);
        fetch_idx = FAW'(LDR_BASE + int'(i_fetch_pc));
      end
      else
      begin
        fetch_int = (int'(i_fetch_pc) < APP_BYTES);
        fetch_idx = FAW'(i_fetch_pc);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_fetch_valid <= 1'b0;
      o_fetch_ext   <= 1'b0;
      o_fetch_data  <= 8'h00;
    end
    else
    begin
      o_fetch_valid <= i_fetch_valid && strap_done_reg;
      o_fetch_ext   <= i_fetch_valid && strap_done_reg && !fetch_int;
      o_fetch_data  <= fetch_int ? flash_mem[fetch_idx] : 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_vec_valid <= 1'b0;
      o_vec_pc    <= `MPM_RESET_PC;
    end
    else
    begin
      o_vec_valid <= i_vec_valid;
      if (i_vec_valid)
        o_vec_pc <= vec_addr(i_vec_num);
    end
  end

  // Internal scratch-pad RAM, its own space
  always_ff @(posedge i_clk)
  begin
    if (i_iram_valid && i_iram_we)
      iram_mem[IAW'(i_iram_addr)] <= i_iram_wdata;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_iram_valid <= 1'b0;
      o_iram_rdata <= 8'h00;
    end
    else
    begin
      o_iram_valid <= i_iram_valid;
      o_iram_rdata <= iram_mem[IAW'(i_iram_addr)];
    end
  end

  // External data move: auxiliary RAM at the bottom, pins above it
  logic [15:0] xaddr;
  logic        x_aux;
  logic        x_ext;
  assign xaddr = i_xdata.wide ? i_xdata.addr : {i_xdata.page, i_xdata.addr[7:0]};
  assign x_aux = (int'(xaddr) < AUXILIARY_RAM_BYTES);
  assign x_ext = i_xdata_valid && !x_aux;

  always_ff @(posedge i_clk)
  begin
    if (i_xdata_valid && x_aux && i_xdata.we)
      auxiliary_ram_mem[XAW'(xaddr)] <= i_xdata.wdata;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_xdata_valid <= 1'b0;
      o_xdata_ext   <= 1'b0;
      o_xdata_rdata <= 8'h00;
    end
    else
    begin
      o_xdata_valid <= i_xdata_valid;
      o_xdata_ext   <= x_ext;
      o_xdata_rdata <= x_aux ? auxiliary_ram_mem[XAW'(xaddr)] : 8'h00;
    end
  end

  // One external bus; a data move wins over an external fetch in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ext_addr  <= 16'h0000;
      o_ext_wdata <= 8'h00;
      o_ext_rd_n  <= 1'b1;
      o_ext_wr_n  <= 1'b1;
      o_psen_n    <= 1'b1;
    end
    else
    begin
      o_ext_rd_n <= !(x_ext && !i_xdata.we);
      o_ext_wr_n <= !(x_ext && i_xdata.we);
      o_psen_n   <= !(!x_ext && i_fetch_valid && strap_done_reg && !fetch_int);
      if (x_ext)
      begin
        o_ext_addr  <= xaddr;
        o_ext_wdata <= i_xdata.wdata;
      end
      else if (i_fetch_valid && !fetch_int)
        o_ext_addr <= i_fetch_pc;
    end
  end

  // Flash controller
  mpm_fl_state_t        fl_state_reg;
  logic [FAW-1:0]       fl_page_reg;
  logic [`MPM_PAGE_AW-1:0] fl_cnt_reg;
  logic                 fl_ok;
  logic                 fl_we;
  logic [FAW-1:0]       fl_widx;
  logic [7:0]           fl_wdata;
  logic [FAW-1:0]       fl_idx;

  // A boot bank may rewrite the other bank and data flash, never itself
  always_comb
  begin
    fl_ok = (int'(i_flash.addr) < bank_bytes(i_flash.bank)) && (i_flash.op != MPM_OP_NONE);
    if (!i_flash.tool && (i_flash.op != MPM_OP_READ))
    begin
      unique case (i_flash.bank)
        MPM_BANK_APP:  fl_ok = fl_ok && boot_ldr_reg;
        MPM_BANK_LDR:  fl_ok = fl_ok && !boot_ldr_reg;
        MPM_BANK_DATA: fl_ok = fl_ok;
        MPM_BANK_CFG:  fl_ok = 1'b0;
      endcase
    end
  end
  assign fl_idx = FAW'(bank_base(i_flash.bank) + int'(i_flash.addr));

  always_comb
  begin
    fl_we    = 1'b0;
    fl_widx  = fl_idx;
    fl_wdata = i_flash.wdata;
    if (fl_state_reg == MPM_FL_ERASE)
    begin
      fl_we    = 1'b1;
      fl_widx  = fl_page_reg | FAW'(fl_cnt_reg);
      fl_wdata = `MPM_ERASED_BYTE;
    end
    else if (i_flash_valid && fl_ok && (i_flash.op == MPM_OP_PROG))
      fl_we = 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (fl_we)
      flash_mem[fl_widx] <= fl_wdata;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fl_state_reg  <= MPM_FL_IDLE;
      fl_page_reg   <= '0;
      fl_cnt_reg    <= '0;
      o_flash_busy  <= 1'b0;
      o_flash_done  <= 1'b0;
      o_flash_err   <= 1'b0;
      o_flash_rdata <= 8'h00;
    end
    else
    begin
      o_flash_done <= 1'b0;
      o_flash_err  <= 1'b0;
      unique case (fl_state_reg)
        MPM_FL_IDLE:
          if (i_flash_valid)
          begin
            if (!fl_ok)
            begin
              o_flash_err  <= 1'b1;
              o_flash_done <= 1'b1;
            end
            else if (i_flash.op == MPM_OP_ERASE)
            begin
              fl_state_reg <= MPM_FL_ERASE;
              fl_page_reg  <= fl_idx & ~FAW'(PB - 1);
              fl_cnt_reg   <= '0;
              o_flash_busy <= 1'b1;
            end
            else
            begin
              o_flash_done <= 1'b1;
              if (i_flash.op == MPM_OP_READ)
                o_flash_rdata <= flash_mem[fl_idx];
            end
          end
        MPM_FL_ERASE:
        begin
          fl_cnt_reg <= fl_cnt_reg + 1'b1;
          if (&fl_cnt_reg)
          begin
            fl_state_reg <= MPM_FL_IDLE;
            o_flash_busy <= 1'b0;
            o_flash_done <= 1'b1;
          end
        end
      endcase
    end
  end

  // Address latch strobe: one high clock per period of three or six clocks
  logic [2:0] ale_cnt_reg;
  logic [2:0] ale_div;
  assign ale_div = i_six_clock_cycle_mode ? `MPM_ALE_DIV_6T : `MPM_ALE_DIV_12T;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ale_cnt_reg <= 3'h0;
      o_ale       <= 1'b0;
    end
    else
    begin
      ale_cnt_reg <= (ale_cnt_reg >= ale_div - 3'h1) ? 3'h0 : ale_cnt_reg + 3'h1;
      o_ale       <= (ale_cnt_reg == 3'h0);
    end
  end

  chk_strap_held: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_strap_done |=> $stable(o_ext_access_locked) && $stable(o_boot_loader))
    else $error("strap changed after capture");
  chk_vec_spacing: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_vec_valid |=> o_vec_valid && o_vec_pc == 16'h0003 + 16'(($past(i_vec_num)) * 8))
    else $error("vector address wrong");
  chk_all_external: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_strap_done && !o_ext_access_locked && i_fetch_valid |=> o_fetch_ext && !o_psen_n || !o_ext_rd_n || !o_ext_wr_n)
    else $error("fetch not external with select low");
  chk_reset_internal: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_strap_done && o_ext_access_locked && i_fetch_valid && i_fetch_pc == 16'h0000 |=> !o_fetch_ext)
    else $error("reset address not internal");
  chk_beyond_ext: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_strap_done && o_ext_access_locked && !o_boot_loader && i_fetch_valid && int'(i_fetch_pc) >= APP_BYTES
    |=> o_fetch_ext)
    else $error("fetch past bank not external");
  chk_xdata_strobe: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    x_ext && !i_xdata.we |=> !o_ext_rd_n && o_ext_wr_n && o_ext_addr == $past(xaddr)
    ##1 (o_ext_rd_n || $past(x_ext && !i_xdata.we)))
    else $error("read strobe wrong");
  chk_aux_internal: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_xdata_valid && int'(xaddr) < AUXILIARY_RAM_BYTES |=> o_ext_rd_n && o_ext_wr_n && !o_xdata_ext)
    else $error("auxiliary RAM leaked to pins");
  chk_erase_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_flash_busy) |-> ##256 $fell(o_flash_busy) && o_flash_done)
    else $error("erase not one page long");
  chk_self_prog: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_flash_valid && !o_flash_busy && !i_flash.tool && i_flash.op == MPM_OP_PROG &&
    i_flash.bank == MPM_BANK_APP && !o_boot_loader |=> o_flash_err)
    else $error("application bank wrote itself");
  chk_ale_6t: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_six_clock_cycle_mode [*4] ##0 o_ale |=> !o_ale ##1 !o_ale ##1 o_ale)
    else $error("strobe rate wrong in six-clock mode");
  cov_loader_boot: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_boot_loader && o_fetch_valid && !o_fetch_ext);
  cov_erase_done: cover property (@(posedge i_clk) disable iff (!i_rst_n) $fell(o_flash_busy));
  cov_ext_write: cover property (@(posedge i_clk) disable iff (!i_rst_n) !o_ext_wr_n);
endmodule // mpm_memory_map

// >>> bench/mpm_ext_mem.sv
// External program and data memory seen from the mapper's pins
`timescale 1ns/1ps
module mpm_ext_mem (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_ext_addr,
  input  wire logic [7:0]  i_ext_wdata,
  input  wire logic        i_ext_rd_n,
  input  wire logic        i_ext_wr_n,
  input  wire logic        i_psen_n,
  output logic [15:0]      o_last_addr,
  output logic [7:0]       o_last_wdata,
  output logic [7:0]       o_strobe_count
);
  // Strobes are one clock wide, so each low sample is one access
  initial
  begin
    o_last_addr    = 16'h0000;
    o_last_wdata   = 8'h00;
    o_strobe_count = 8'h00;
    forever
    begin
      @(posedge i_clk);
      if (!i_ext_wr_n || !i_ext_rd_n || !i_psen_n)
      begin
        o_last_addr    <= i_ext_addr;
        o_last_wdata   <= i_ext_wdata;
        o_strobe_count <= o_strobe_count + 8'h01;
      end
    end
  end
endmodule // mpm_ext_mem

// >>> bench/program_memory_map_vectoring_bench.sv
// Self-checking bench for the program and data memory mapper
`timescale 1ns/1ps
module program_memory_map_vectoring_bench;
  import mpm_pkg::*;
  typedef struct packed {logic [4:0] num; logic [15:0] pc;} mpm_vec_row_t;
  logic i_clk, i_rst_n, i_external_access_select, i_boot_loader, i_six_clock_cycle_mode;
  logic i_fetch_valid, i_vec_valid, i_iram_valid, i_iram_we, i_xdata_valid, i_flash_valid;
  logic [15:0] i_fetch_pc;
  logic [4:0] i_vec_num;
  logic [7:0] i_iram_addr, i_iram_wdata;
  mpm_xdata_req_t i_xdata;
  mpm_flash_req_t i_flash;
  logic o_fetch_valid, o_fetch_ext, o_psen_n, o_ext_rd_n, o_ext_wr_n, o_vec_valid, o_iram_valid;
  logic o_xdata_valid, o_xdata_ext, o_flash_busy, o_flash_done, o_flash_err, o_ale;
  logic o_boot_loader, o_ext_access_locked, o_strap_done;
  logic [7:0] o_fetch_data, o_ext_wdata, o_iram_rdata, o_xdata_rdata, o_flash_rdata;
  logic [15:0] o_ext_addr, o_vec_pc, last_addr;
  logic [7:0] last_wdata, strobe_count;
  int bad_count = 0;
  int samples_checked = 0;
  int n;
  mpm_vec_row_t rows[5] = '{'{5'h00, 16'h0003}, '{5'h01, 16'h000B}, '{5'h02, 16'h0013},
                            '{5'h03, 16'h001B}, '{5'h1F, 16'h00FB}};

  mpm_memory_map #(.APP_PAGES(4)) DUT (.i_clk, .i_rst_n, .i_external_access_select, .i_boot_loader,
    .i_six_clock_cycle_mode, .i_fetch_valid, .i_fetch_pc, .i_vec_valid, .i_vec_num, .i_iram_valid,
    .i_iram_we, .i_iram_addr, .i_iram_wdata, .i_xdata_valid, .i_xdata, .i_flash_valid, .i_flash,
    .o_fetch_valid, .o_fetch_ext, .o_fetch_data, .o_psen_n, .o_ext_addr, .o_ext_wdata, .o_ext_rd_n,
    .o_ext_wr_n, .o_vec_valid, .o_vec_pc, .o_iram_valid, .o_iram_rdata, .o_xdata_valid, .o_xdata_ext,
    .o_xdata_rdata, .o_flash_busy, .o_flash_done, .o_flash_err, .o_flash_rdata, .o_ale, .o_boot_loader,
    .o_ext_access_locked, .o_strap_done);
  mpm_ext_mem ext (.i_clk(i_clk), .i_ext_addr(o_ext_addr), .i_ext_wdata(o_ext_wdata),
    .i_ext_rd_n(o_ext_rd_n), .i_ext_wr_n(o_ext_wr_n), .i_psen_n(o_psen_n), .o_last_addr(last_addr),
    .o_last_wdata(last_wdata), .o_strobe_count(strobe_count));

  initial i_clk = 1'b0;
  always #20 i_clk = ~i_clk;

  task tick;
    @(posedge i_clk);
    #1;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task do_reset(input logic ea, input logic boot);
    i_rst_n = 1'b0;
    i_external_access_select = ea;
    i_boot_loader = boot;
    repeat (12) tick;
    chk("idle_strobes", 16'h0007, {13'h0, o_psen_n, o_ext_rd_n, o_ext_wr_n});
    chk("reset_vec_pc", 16'h0000, o_vec_pc);
    i_rst_n = 1'b1;
    tick;
    tick;
    chk("strap_boot", {15'h0, boot}, {15'h0, o_boot_loader});
    chk("strap_done", 16'h0001, {15'h0, o_strap_done});
    chk("strap_select", {15'h0, ea}, {15'h0, o_ext_access_locked});
  endtask
  task fetch(input logic [15:0] pc, input logic ext, input logic [7:0] d);
    i_fetch_valid = 1'b1;
    i_fetch_pc = pc;
    tick;
    i_fetch_valid = 1'b0;
    chk("fetch_valid", 16'h0001, {15'h0, o_fetch_valid});
    chk("fetch_ext", {15'h0, ext}, {15'h0, o_fetch_ext});
    chk("fetch_data", {8'h00, d}, {8'h00, o_fetch_data});
    if (ext)
    begin
      chk("psen_n", 16'h0000, {15'h0, o_psen_n});
      chk("ext_addr", pc, o_ext_addr);
    end
    tick;
  endtask
  task flash(input mpm_op_t op, input mpm_bank_t bk, input logic tool, input logic [15:0] a,
             input logic [7:0] d, input logic err);
    i_flash_valid = 1'b1;
    i_flash = '{op:op, bank:bk, tool:tool, addr:a, wdata:d};
    tick;
    i_flash_valid = 1'b0;
    chk("flash_busy", {15'h0, op == MPM_OP_ERASE && !err}, {15'h0, o_flash_busy});
    n = 0;
    while (o_flash_done !== 1'b1 && n < 300)
    begin
      tick;
      n++;
    end
    chk("flash_err", {15'h0, err}, {15'h0, o_flash_err});
    if (op == MPM_OP_READ && !err)
      chk("flash_rdata", {8'h00, d}, {8'h00, o_flash_rdata});
    if (op == MPM_OP_ERASE)
      chk("erase_len", 16'h0100, n[15:0]);
    tick;
  endtask
  task xd(input logic we, input logic wide, input logic [7:0] pg, input logic [15:0] a,
          input logic [7:0] d);
    i_xdata_valid = 1'b1;
    i_xdata = '{we:we, wide:wide, page:pg, addr:a, wdata:d};
    // Request stays up so back-to-back moves need no idle cycle; the caller drops it
    tick;
  endtask
  task ale_period(input logic six, input int exp);
    i_six_clock_cycle_mode = six;
    repeat (8) tick;
    while (o_ale !== 1'b1 && n < 20) tick;
    n = 0;
    tick;
    while (o_ale !== 1'b1 && n < 20)
    begin
      tick;
      n++;
    end
    chk("ale_period", exp[15:0], n[15:0] + 16'h0001);
  endtask
  task finish_test;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #(40 * 8000);
    bad_count++;
    finish_test;
  end

  initial
  begin
    {i_fetch_valid, i_vec_valid, i_iram_valid, i_iram_we, i_xdata_valid, i_flash_valid} = '0;
    {i_fetch_pc, i_vec_num, i_iram_addr, i_iram_wdata, i_xdata, i_flash} = '0;
    i_six_clock_cycle_mode = 1'b1;
    do_reset(1'b1, 1'b0);
    foreach (rows[i])
    begin
      i_vec_valid = 1'b1;
      i_vec_num = rows[i].num;
      tick;
      chk("vec_valid", 16'h0001, {15'h0, o_vec_valid});
      chk("vec_pc", rows[i].pc, o_vec_pc);
    end
    i_vec_valid = 1'b0;
    $display("test vectors done");
    i_external_access_select = 1'b0;
    flash(MPM_OP_PROG, MPM_BANK_APP, 1'b1, 16'h0003, 8'hA5, 1'b0);
    fetch(16'h0003, 1'b0, 8'hA5);
    flash(MPM_OP_PROG, MPM_BANK_APP, 1'b1, 16'h03FF, 8'h6B, 1'b0);
    fetch(16'h03FF, 1'b0, 8'h6B);
    fetch(16'h0400, 1'b1, 8'h00);
    flash(MPM_OP_READ, MPM_BANK_APP, 1'b0, 16'h0003, 8'hA5, 1'b0);
    flash(MPM_OP_ERASE, MPM_BANK_APP, 1'b1, 16'h0010, 8'h00, 1'b0);
    fetch(16'h0003, 1'b0, 8'hFF);
    flash(MPM_OP_READ, MPM_BANK_DATA, 1'b0, 16'h0800, 8'h00, 1'b1);
    flash(MPM_OP_READ, MPM_BANK_CFG, 1'b0, 16'h0100, 8'h00, 1'b1);
    flash(MPM_OP_NONE, MPM_BANK_DATA, 1'b0, 16'h0000, 8'h00, 1'b1);
    flash(MPM_OP_PROG, MPM_BANK_APP, 1'b0, 16'h0004, 8'h11, 1'b1);
    flash(MPM_OP_PROG, MPM_BANK_LDR, 1'b0, 16'h0000, 8'h3C, 1'b0);
    $display("test flash done");
    i_iram_valid = 1'b1;
    i_iram_we = 1'b1;
    i_iram_addr = 8'h10;
    i_iram_wdata = 8'h77;
    tick;
    i_iram_we = 1'b0;
    xd(1'b1, 1'b1, 8'h00, 16'h0010, 8'h99);
    xd(1'b0, 1'b1, 8'h00, 16'h0010, 8'h00);
    i_xdata_valid = 1'b0;
    chk("aux_rdata", 16'h0099, {8'h00, o_xdata_rdata});
    chk("xdata_ext", 16'h0000, {15'h0, o_xdata_ext});
    chk("xdata_valid", 16'h0001, {15'h0, o_xdata_valid});
    i_iram_valid = 1'b1;
    tick;
    i_iram_valid = 1'b0;
    chk("iram_rdata", 16'h0077, {8'h00, o_iram_rdata});
    chk("iram_valid", 16'h0001, {15'h0, o_iram_valid});
    n = strobe_count;
    xd(1'b1, 1'b1, 8'h00, 16'h1234, 8'h5E);
    chk("wr_strobe", 16'h0001, {14'h0, o_ext_wr_n, o_ext_rd_n});
    chk("wr_addr", 16'h1234, o_ext_addr);
    xd(1'b0, 1'b0, 8'hFF, 16'h0078, 8'h00);
    i_xdata_valid = 1'b0;
    chk("rd_strobe", 16'h0002, {14'h0, o_ext_wr_n, o_ext_rd_n});
    chk("rd_addr", 16'hFF78, o_ext_addr);
    chk("xdata_ext", 16'h0001, {15'h0, o_xdata_ext});
    chk("ext_wdata", 16'h005E, {8'h00, last_wdata});
    tick;
    chk("ext_seen", 16'hFF78, last_addr);
    chk("ext_strobes", {8'h00, 8'(n + 2)}, {8'h00, strobe_count});
    $display("test data spaces done");
    ale_period(1'b1, 3);
    ale_period(1'b0, 6);
    $display("test ale done");
    do_reset(1'b1, 1'b1);
    flash(MPM_OP_PROG, MPM_BANK_LDR, 1'b1, 16'h0003, 8'h5A, 1'b0);
    flash(MPM_OP_PROG, MPM_BANK_LDR, 1'b0, 16'h0004, 8'h22, 1'b1);
    flash(MPM_OP_PROG, MPM_BANK_APP, 1'b0, 16'h0003, 8'hC3, 1'b0);
    fetch(16'h0000, 1'b0, 8'h3C);
    fetch(16'h0003, 1'b0, 8'h5A);
    fetch(16'h1000, 1'b1, 8'h00);
    $display("test loader boot done");
    do_reset(1'b0, 1'b0);
    i_external_access_select = 1'b1;
    fetch(16'h0003, 1'b1, 8'h00);
    fetch(16'h0000, 1'b1, 8'h00);
    do_reset(1'b1, 1'b0);
    flash(MPM_OP_READ, MPM_BANK_APP, 1'b0, 16'h0003, 8'hC3, 1'b0);
    $display("test external boot done");
    finish_test;
  end
endmodule // program_memory_map_vectoring_bench
